/* File: hw/acc_unit_defines.svh */
// constants for the accumulator conversion, rotate and interrupt mask unit
`ifndef ACC_UNIT_DEFINES_SVH
`define ACC_UNIT_DEFINES_SVH
`define ACC_WIDTH           32
`define MASK_RESET          32'h000003FF
`define MASK_USED           32'h000003FF
`define SYSERR_BIT          0
`define HANDLER_FIRST       1
`define HANDLER_COUNT       9
`define BCD_WORD_MAX        16'h03E7
`define BCD_DWORD_MAX       32'h0098967F
`define FLOAT_BIAS          8'h7F
`define FLOAT_FIX_EXP_MAX   8'h9D
`endif

/* File: hw/acc_unit_pkg.sv */
// types for the accumulator conversion, rotate and interrupt mask unit
package acc_unit_pkg;
	typedef enum logic [4:0] {
		OP_NONE,
		OP_ROTATE_LEFT_DWORD,
		OP_ROTATE_RIGHT_DWORD,
		OP_ONES_COMPLEMENT_WORD,
		OP_TWOS_COMPLEMENT_WORD,
		OP_TWOS_COMPLEMENT_DWORD,
		OP_BCD_TO_BINARY_WORD,
		OP_BINARY_TO_BCD_WORD,
		OP_BCD_TO_BINARY_DWORD,
		OP_BINARY_TO_BCD_DWORD,
		OP_FIXED_TO_FLOAT,
		OP_FLOAT_TO_FIXED,
		OP_INCREMENT,
		OP_DECREMENT,
		OP_GLOBAL_IRQ_DISABLE,
		OP_GLOBAL_IRQ_ENABLE,
		OP_WRITE_IRQ_MASK,
		OP_READ_IRQ_MASK
	} acc_op_e;

	typedef struct packed {
		logic        valid;
		acc_op_e     op;
		logic [7:0]  param;
		logic [31:0] primary_accumulator;
		logic [31:0] secondary_accumulator;
		logic        logic_result_bit;
		logic        cond_code_upper;
		logic        cond_code_lower;
	} acc_req_s;

	typedef struct packed {
		logic        done;
		logic [31:0] primary_accumulator;
		logic [31:0] secondary_accumulator;
		logic        logic_result_bit;
		logic        cond_code_upper;
		logic        cond_code_lower;
	} acc_rsp_s;

	typedef struct packed {
		acc_rsp_s    rsp;
		logic [31:0] interrupt_enable_mask;
		logic        irq_global_enable;
		logic [9:0]  pending;
		logic [9:0]  grant;
	} acc_state_s;
endpackage

/* File: hw/acc_unit.sv */
// accumulator rotate, conversion, increment and interrupt mask unit
//
// Summary of operation
// - rotates unconditional, logic bit kept, codes set unless count is zero
// - rotate by count, wrapping bits around
// - ones complement inverts low half only
// - 16-bit negate, high half gets sign
// - 32-bit negate of whole accumulator
// - signed 3-digit bcd low half to binary
// - low half binary to signed 3-digit bcd
// - 7-digit bcd dword to binary
// - binary dword to bcd
// - integer to float conversion
// - float to integer rounds down, exact integers
// - values between minus one and zero give zero
// - conversions ignore logic bit, keep secondary
// - inc/dec act on lowest byte only
// - inc/dec leave logic bit and codes
// - global disable blocks time/process handlers
// - requests while disabled stay pending
// - system error gated only by bit 0
// - mask write/read via accumulator, flags kept
// - one mask bit per handler, set enables
// - reset presets mask bits 0 to 9
// - left and right rotate on full dword
`timescale 1ns/1ps
`include "acc_unit_defines.svh"

module acc_unit
	import acc_unit_pkg::*;
(
	input  wire logic      clock,
	input  wire logic      rst_n,
	input  wire acc_req_s  req,
	input  wire logic [9:0] irq_request,
	input  wire logic [9:0] irq_done,
	output acc_rsp_s       rsp,
	output logic [9:0]     irq_grant,
	output logic           irq_global_enable
);
	acc_state_s state_ff;
	acc_state_s nxt_state;

	function automatic logic [31:0] rot_left(input logic [31:0] v, input logic [4:0] n);
		rot_left = (v << n) | (v >> (6'd32 - {1'b0, n}));
	endfunction

	function automatic logic bcd_bad(input logic [27:0] v, input int digits);
		bcd_bad = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (i < digits && v[i*4 +: 4] > 4'h9) begin
				bcd_bad = 1'b1;
			end
		end
	endfunction

	function automatic logic [31:0] bcd_to_bin(input logic [27:0] v);
		bcd_to_bin = 32'h00000000;
		for (int i = 6; i >= 0; i--) begin
			bcd_to_bin = bcd_to_bin * 32'd10 + {28'h0000000, v[i*4 +: 4]};
		end
	endfunction

	// double dabble, fixed loop so always bounded
	function automatic logic [39:0] bin_to_bcd(input logic [31:0] v);
		bin_to_bcd = 40'h0000000000;
		for (int i = 31; i >= 0; i--) begin
			for (int d = 0; d < 10; d++) begin
				if (bin_to_bcd[d*4 +: 4] > 4'h4) begin
					bin_to_bcd[d*4 +: 4] = bin_to_bcd[d*4 +: 4] + 4'h3;
				end
			end
			bin_to_bcd = {bin_to_bcd[38:0], v[i]};
		end
	endfunction

	// single precision layout: sign, 8-bit biased exponent, 23-bit fraction
	function automatic logic [31:0] fix_to_float(input logic [31:0] v);
		logic [31:0] mag;
		logic [7:0]  msb;
		logic [31:0] norm;
		mag = v[31] ? (~v + 32'h00000001) : v;
		msb = 8'h00;
		for (int i = 0; i < 32; i++) begin
			if (mag[i]) begin
				msb = 8'(i);
			end
		end
		norm = mag << (8'd31 - msb);
		// truncation of low bits above 2^24: magnitude may lose precision
		if (mag == 32'h00000000) begin
			fix_to_float = 32'h00000000;
		end else begin
			fix_to_float = {v[31], msb + `FLOAT_BIAS, norm[30:8]};
		end
	endfunction

	function automatic logic [32:0] float_to_fix(input logic [31:0] f);
		logic [7:0]  e;
		logic [55:0] mant;
		logic [31:0] ip;
		logic        frac;
		e = f[30:23];
		mant = {32'h00000000, 1'b1, f[22:0]};
		ip = 32'h00000000;
		frac = 1'b0;
		float_to_fix = 33'h000000000;
		if (e > `FLOAT_FIX_EXP_MAX) begin
			float_to_fix = 33'h100000000;
		end else if (e >= `FLOAT_BIAS) begin
			mant = mant << (e - `FLOAT_BIAS);
			ip = mant[54:23];
			frac = |mant[22:0];
			float_to_fix = {1'b0, f[31] ? (~ip + 32'h00000001 - {31'h0, frac}) : ip};
		end else if (e != 8'h00 && !f[31]) begin
			float_to_fix = 33'h000000000;
		end
		// minus one to zero gives zero
		if (f[31] && e < `FLOAT_BIAS) begin
			float_to_fix = 33'h000000000;
		end
	endfunction

	always_comb begin
		logic [31:0] a;
		logic [31:0] r;
		logic [39:0] b;
		logic [32:0] ff;
		logic [9:0]  eligible;
		logic [15:0] m16;
		a = req.primary_accumulator;
		r = 32'h00000000;
		b = 40'h0000000000;
		ff = 33'h000000000;
		m16 = 16'h0000;
		eligible = 10'h000;
		nxt_state = state_ff;
		nxt_state.rsp.done = 1'b0;
		if (req.valid) begin
			nxt_state.rsp.done = 1'b1;
			nxt_state.rsp.primary_accumulator = a;
			nxt_state.rsp.secondary_accumulator = req.secondary_accumulator;
			nxt_state.rsp.logic_result_bit = req.logic_result_bit;
			nxt_state.rsp.cond_code_upper = req.cond_code_upper;
			nxt_state.rsp.cond_code_lower = req.cond_code_lower;
			unique case (req.op)
				OP_NONE: begin
				end
				OP_ROTATE_LEFT_DWORD, OP_ROTATE_RIGHT_DWORD: begin
					if (req.param[4:0] != 5'h00) begin
						r = (req.op == OP_ROTATE_LEFT_DWORD) ? rot_left(a, req.param[4:0])
							: rot_left(a, 5'(6'd32 - {1'b0, req.param[4:0]}));
						nxt_state.rsp.primary_accumulator = r;
						nxt_state.rsp.cond_code_upper = (req.op == OP_ROTATE_LEFT_DWORD) ? r[0] : r[31];
						nxt_state.rsp.cond_code_lower = 1'b0;
					end
				end
				OP_ONES_COMPLEMENT_WORD: begin
					nxt_state.rsp.primary_accumulator = {a[31:16], ~a[15:0]};
				end
				OP_TWOS_COMPLEMENT_WORD: begin
					m16 = ~a[15:0] + 16'h0001;
					nxt_state.rsp.primary_accumulator = {{16{m16[15]}}, m16};
				end
				OP_TWOS_COMPLEMENT_DWORD: begin
					nxt_state.rsp.primary_accumulator = ~a + 32'h00000001;
				end
				OP_BCD_TO_BINARY_WORD: begin
					r = bcd_to_bin({16'h0000, a[11:0]});
					if (bcd_bad({16'h0000, a[11:0]}, 3)) begin
						nxt_state.rsp.cond_code_upper = 1'b1;
						nxt_state.rsp.cond_code_lower = 1'b1;
					end else begin
						m16 = a[15] ? (~r[15:0] + 16'h0001) : r[15:0];
						nxt_state.rsp.primary_accumulator = {a[31:16], m16};
					end
				end
				OP_BINARY_TO_BCD_WORD: begin
					m16 = a[15] ? (~a[15:0] + 16'h0001) : a[15:0];
					if (m16 > `BCD_WORD_MAX) begin
						nxt_state.rsp.cond_code_upper = 1'b1;
						nxt_state.rsp.cond_code_lower = 1'b1;
					end else begin
						b = bin_to_bcd({16'h0000, m16});
						nxt_state.rsp.primary_accumulator = {a[31:16], {4{a[15]}}, b[11:0]};
					end
				end
				OP_BCD_TO_BINARY_DWORD: begin
					if (bcd_bad(a[27:0], 7)) begin
						nxt_state.rsp.cond_code_upper = 1'b1;
						nxt_state.rsp.cond_code_lower = 1'b1;
					end else begin
						r = bcd_to_bin(a[27:0]);
						nxt_state.rsp.primary_accumulator = a[31] ? (~r + 32'h00000001) : r;
					end
				end
				// dword to bcd, sign in top nibble
				OP_BINARY_TO_BCD_DWORD: begin
					r = a[31] ? (~a + 32'h00000001) : a;
					if (r > `BCD_DWORD_MAX) begin
						nxt_state.rsp.cond_code_upper = 1'b1;
						nxt_state.rsp.cond_code_lower = 1'b1;
					end else begin
						b = bin_to_bcd(r);
						nxt_state.rsp.primary_accumulator = {{4{a[31]}}, b[27:0]};
					end
				end
				OP_FIXED_TO_FLOAT: begin
					nxt_state.rsp.primary_accumulator = fix_to_float(a);
				end
				OP_FLOAT_TO_FIXED: begin
					ff = float_to_fix(a);
					nxt_state.rsp.primary_accumulator = ff[31:0];
					if (ff[32]) begin
						nxt_state.rsp.cond_code_upper = 1'b1;
						nxt_state.rsp.cond_code_lower = 1'b1;
					end
				end
				OP_INCREMENT: begin
					nxt_state.rsp.primary_accumulator = {a[31:8], a[7:0] + req.param};
				end
				OP_DECREMENT: begin
					nxt_state.rsp.primary_accumulator = {a[31:8], a[7:0] - req.param};
				end
				OP_GLOBAL_IRQ_DISABLE: begin
					nxt_state.irq_global_enable = 1'b0;
				end
				OP_GLOBAL_IRQ_ENABLE: begin
					nxt_state.irq_global_enable = 1'b1;
				end
				OP_WRITE_IRQ_MASK: begin
					nxt_state.interrupt_enable_mask = a & `MASK_USED;
				end
				OP_READ_IRQ_MASK: begin
					nxt_state.rsp.primary_accumulator = state_ff.interrupt_enable_mask;
				end
				default: begin
				end
			endcase
		end
		// requests latch until serviced; set wins over clear
		nxt_state.pending = (state_ff.pending & ~irq_done) | irq_request;
		// per-bit enable, bit 0 ignores global gate
		for (int i = 0; i < 10; i++) begin
			eligible[i] = state_ff.pending[i] & state_ff.interrupt_enable_mask[i]
				& ((i == `SYSERR_BIT) | state_ff.irq_global_enable);
		end
		nxt_state.grant = eligible;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
			state_ff.interrupt_enable_mask <= `MASK_RESET;
			state_ff.irq_global_enable <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rsp = state_ff.rsp;
	assign irq_grant = state_ff.grant;
	assign irq_global_enable = state_ff.irq_global_enable;

	AST_ROT_LRB: assert property (@(posedge clock) disable iff (!rst_n)
		req.valid && req.op == OP_ROTATE_LEFT_DWORD |=> rsp.done
		&& rsp.logic_result_bit == $past(req.logic_result_bit))
		else $error("rotate changed logic bit");
	AST_INC_BYTE: assert property (@(posedge clock) disable iff (!rst_n)
		req.valid && req.op == OP_INCREMENT |=> rsp.primary_accumulator[31:8]
		== $past(req.primary_accumulator[31:8]))
		else $error("increment carried into upper bytes");
	AST_NEG32: assert property (@(posedge clock) disable iff (!rst_n)
		req.valid && req.op == OP_TWOS_COMPLEMENT_DWORD |=> rsp.primary_accumulator
		+ $past(req.primary_accumulator) == 32'h00000000)
		else $error("dword negate wrong");
	AST_GATE_OFF: assert property (@(posedge clock) disable iff (!rst_n)
		!irq_global_enable |=> irq_grant[9:1] == 9'h000)
		else $error("handler granted while globally disabled");
	AST_SYSERR: assert property (@(posedge clock) disable iff (!rst_n)
		!state_ff.interrupt_enable_mask[0] |=> !irq_grant[0])
		else $error("system error granted while masked");
	AST_MASK_RD: assert property (@(posedge clock) disable iff (!rst_n)
		req.valid && req.op == OP_READ_IRQ_MASK |=> rsp.primary_accumulator[31:10] == 22'h000000)
		else $error("mask upper bits not zero");
	AST_PEND: assert property (@(posedge clock) disable iff (!rst_n)
		irq_request[3] |=> state_ff.pending[3])
		else $error("request lost");
	AST_SECOND: assert property (@(posedge clock) disable iff (!rst_n)
		req.valid |=> rsp.secondary_accumulator == $past(req.secondary_accumulator))
		else $error("secondary accumulator changed");
endmodule // acc_unit

/* File: testbench/irq_source_model.sv */
// interrupt source model that holds each request until it is granted
`timescale 1ns/1ps

module irq_source_model
	import acc_unit_pkg::*;
(
	input  wire logic [9:0] raise,
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [9:0] irq_grant,
	output logic      [9:0] irq_request,
	output logic      [9:0] irq_done,
	output logic      [9:0] served
);
	// request held as a level, so a late grant still finds it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_request <= '0;
			irq_done <= '0;
			served <= '0;
		end else begin
			irq_request <= (irq_request | raise) & ~irq_grant;
			irq_done <= irq_grant & ~irq_done;
			served <= served | irq_grant;
		end
	end
endmodule // irq_source_model

/* File: testbench/tb.sv */
// self-checking bench for the accumulator and interrupt mask unit
`timescale 1ns/1ps

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %0t: got %h want %h", $time, (g), (e)); end end

module tb
	import acc_unit_pkg::*;
;
	typedef struct packed {
		acc_op_e     op;
		logic [7:0]  p;
		logic [31:0] a;
		logic [31:0] e;
		logic [2:0]  cc;
	} row_s;

	logic       clock;
	logic       rst_n;
	acc_req_s   req;
	acc_rsp_s   rsp;
	logic [9:0] irq_request;
	logic [9:0] irq_done;
	logic [9:0] irq_grant;
	logic       irq_global_enable;
	logic [9:0] raise;
	logic [9:0] served;
	int         fails = 0;
	int         compares = 0;
	int         i;
	// cc: check flag, then expected upper and lower codes
	row_s rows [18] = '{
		'{OP_ROTATE_LEFT_DWORD, 8'h04, 32'h9000_0001, 32'h0000_0019, 3'h6},
		'{OP_ROTATE_RIGHT_DWORD, 8'h01, 32'h0000_0003, 32'h8000_0001, 3'h6},
		'{OP_ONES_COMPLEMENT_WORD, 8'h00, 32'h1234_00FF, 32'h1234_FF00, 3'h0},
		'{OP_TWOS_COMPLEMENT_WORD, 8'h00, 32'h1234_0005, 32'hFFFF_FFFB, 3'h0},
		'{OP_TWOS_COMPLEMENT_WORD, 8'h00, 32'h1234_FFFB, 32'h0000_0005, 3'h0},
		'{OP_TWOS_COMPLEMENT_DWORD, 8'h00, 32'h0000_0001, 32'hFFFF_FFFF, 3'h0},
		'{OP_BCD_TO_BINARY_WORD, 8'h00, 32'hABCD_F123, 32'hABCD_FF85, 3'h0},
		'{OP_BCD_TO_BINARY_WORD, 8'h00, 32'h0000_00A0, 32'h0000_00A0, 3'h7},
		'{OP_BINARY_TO_BCD_WORD, 8'h00, 32'h5555_03E7, 32'h5555_0999, 3'h0},
		'{OP_BINARY_TO_BCD_WORD, 8'h00, 32'h5555_FF85, 32'h5555_F123, 3'h0},
		'{OP_BCD_TO_BINARY_DWORD, 8'h00, 32'h0123_4567, 32'h0012_D687, 3'h0},
		'{OP_BINARY_TO_BCD_DWORD, 8'h00, 32'h0098_967F, 32'h0999_9999, 3'h0},
		'{OP_FIXED_TO_FLOAT, 8'h00, 32'hFFFF_FFFE, 32'hC000_0000, 3'h0},
		'{OP_FLOAT_TO_FIXED, 8'h00, 32'hBFC0_0000, 32'hFFFF_FFFE, 3'h0},
		'{OP_FLOAT_TO_FIXED, 8'h00, 32'hBF80_0000, 32'hFFFF_FFFF, 3'h0},
		'{OP_FLOAT_TO_FIXED, 8'h00, 32'hBF00_0000, 32'h0000_0000, 3'h0},
		'{OP_INCREMENT, 8'h10, 32'h0000_1010, 32'h0000_1020, 3'h5},
		'{OP_DECREMENT, 8'h21, 32'h0000_1020, 32'h0000_10FF, 3'h5}
	};

	acc_unit DUT (
		.clock             (clock),
		.rst_n             (rst_n),
		.req               (req),
		.irq_request       (irq_request),
		.irq_done          (irq_done),
		.rsp               (rsp),
		.irq_grant         (irq_grant),
		.irq_global_enable (irq_global_enable)
	);

	irq_source_model partner (
		.raise       (raise),
		.clock       (clock),
		.rst_n       (rst_n),
		.irq_grant   (irq_grant),
		.irq_request (irq_request),
		.irq_done    (irq_done),
		.served      (served)
	);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic tally_and_finish;
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one request, answer lands at the next edge
	task automatic run(input acc_op_e o, input logic [7:0] p, input logic [31:0] a);
		@(posedge clock);
		#5;
		req.valid = 1'b1;
		req.op = o;
		req.param = p;
		req.primary_accumulator = a;
		@(posedge clock);
		#5;
		req.valid = 1'b0;
	endtask

	initial begin
		req = '0;
		req.secondary_accumulator = 32'hA5A5_5A5A;
		req.logic_result_bit = 1'b1;
		req.cond_code_lower = 1'b1;
		rst_n = 1'b0;
		raise = '0;
		repeat (6) @(posedge clock);
		#5;
		rst_n = 1'b1;
		foreach (rows[k]) begin
			run(rows[k].op, rows[k].p, rows[k].a);
			`CHK(rsp.done, 1'b1)
			`CHK(rsp.primary_accumulator, rows[k].e)
			`CHK(rsp.secondary_accumulator, 32'hA5A5_5A5A)
			`CHK(rsp.logic_result_bit, 1'b1)
			if (rows[k].cc[2])
				`CHK({rsp.cond_code_upper, rsp.cond_code_lower}, rows[k].cc[1:0])
		end
		run(OP_READ_IRQ_MASK, 8'h00, 32'h0);
		`CHK(rsp.primary_accumulator, 32'h0000_03FF)
		run(OP_WRITE_IRQ_MASK, 8'h00, 32'hFFFF_FFFF);
		run(OP_READ_IRQ_MASK, 8'h00, 32'h0);
		`CHK(rsp.primary_accumulator, 32'h0000_03FF)
		`CHK({rsp.logic_result_bit, rsp.cond_code_upper, rsp.cond_code_lower}, 3'h5)
		run(OP_WRITE_IRQ_MASK, 8'h00, 32'h0000_0005);
		run(OP_GLOBAL_IRQ_DISABLE, 8'h00, 32'h0);
		`CHK(irq_global_enable, 1'b0)
		raise = 10'h007;
		@(posedge clock);
		#5;
		raise = '0;
		repeat (8) @(posedge clock);
		#5;
		// system error passes, enabled handler held back
		`CHK(served, 10'h001)
		`CHK(irq_grant, 10'h000)
		run(OP_GLOBAL_IRQ_ENABLE, 8'h00, 32'h0);
		// sample after the edge so the grant has landed
		for (i = 0; i < 10 && served[2] !== 1'b1; i++) begin
			@(posedge clock);
			#5;
		end
		if (served[2] !== 1'b1) begin
			fails++;
			$display("ERROR %0t: pending handler never granted", $time);
			tally_and_finish();
		end
		`CHK(served, 10'h005)
		run(OP_WRITE_IRQ_MASK, 8'h00, 32'h0000_0002);
		repeat (6) @(posedge clock);
		#5;
		`CHK(served, 10'h007)
		tally_and_finish();
	end
endmodule // tb
